//--- cob_out_cell.sv
/*
  cob_out_cell: configuration word and applied drive of one output buffer.
  Assumes write enable and data come from the APB decode in cob_top.
*/
`timescale 1ns/100ps
`default_nettype none
module cob_out_cell
  import cob_pkg::*;
#(
  parameter bit HF_OUT = 1'b0
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // write side
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  // state
  output logic [31:0] rd_word,
  output cob_drive_t drive
);
  cob_cfg_t cfg;
  cob_drive_t next_drive;

  function automatic logic [9:0] swing_of(input logic sty, input logic [1:0] amp);
    logic [9:0] mv;
    mv = COB_MV_700;
    if (sty == COB_STYLE_LVDS)
      mv = amp[1] ? COB_MV_500 : COB_MV_350;
    else
    begin
      case (amp)
        2'h0: mv = COB_MV_300;
        2'h1: mv = COB_MV_400;
        2'h2: mv = COB_MV_550;
        default: mv = COB_MV_700;
      endcase
    end
    return mv;
  endfunction

  // ----------------------------------------
  // stored fields, only this output's word
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cfg <= COB_CFG_RST;
    else if (wr_en)
    begin
      cfg.output_power_down <= wr_data[COB_PD_BIT];
      cfg.sysref_path_power_down <= wr_data[COB_PDSYS_BIT];
      cfg.fine_delay_code <= wr_data[COB_FINE_LSB +: 2];
      cfg.analog_delay_code <= wr_data[COB_ANLG_LSB +: 3];
      cfg.sysref_polarity_invert <= wr_data[COB_INV_BIT];
      // high-frequency outputs hold the lvpecl style bit
      cfg.style <= HF_OUT ? COB_STYLE_PECL : wr_data[COB_STYLE_BIT];
      cfg.amplitude <= wr_data[COB_AMP_LSB +: 2];
    end
  end

  // ----------------------------------------
  // applied drive
  // ----------------------------------------
  always_comb
  begin
    next_drive = '0;
    next_drive.buffer_on = ~cfg.output_power_down & ~cfg.sysref_path_power_down;
    next_drive.delay_on = ~cfg.sysref_path_power_down;
    if (next_drive.buffer_on)
    begin
      next_drive.style = cfg.style;
      next_drive.swing_mv = swing_of(cfg.style, cfg.amplitude);
      next_drive.invert = cfg.sysref_polarity_invert;
    end
    if (next_drive.delay_on)
    begin
      next_drive.analog_ps = 8'(cfg.analog_delay_code * COB_ANLG_STEP_PS);
      next_drive.fine = cfg.fine_delay_code;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      drive <= '0;
    else
      drive <= next_drive;
  end

  assign rd_word = {14'h0000, cfg.output_power_down, cfg.sysref_path_power_down,
    2'h0, cfg.fine_delay_code, 1'h0, cfg.analog_delay_code,
    4'h0, cfg.sysref_polarity_invert, cfg.style, cfg.amplitude};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  pd_gates_swing_a: assert property (@(posedge ref_clk) disable iff (srst)
    cfg.output_power_down |=> drive.swing_mv == COB_MV_OFF && !drive.buffer_on)
    else $error("powered-down output shows a swing");
  sysref_pd_a: assert property (@(posedge ref_clk) disable iff (srst)
    cfg.sysref_path_power_down |=> !drive.delay_on && drive.analog_ps == 8'h00)
    else $error("sysref path power-down leaves delay active");
  lvds_swing_a: assert property (@(posedge ref_clk) disable iff (srst)
    next_drive.buffer_on && cfg.style == COB_STYLE_LVDS |=>
    drive.swing_mv == ($past(cfg.amplitude[1]) ? COB_MV_500 : COB_MV_350))
    else $error("lvds swing wrong");
  invert_on_a: assert property (@(posedge ref_clk) disable iff (srst)
    next_drive.buffer_on |=> drive.invert == $past(cfg.sysref_polarity_invert))
    else $error("sysref polarity not applied");
  analog_delay_a: assert property (@(posedge ref_clk) disable iff (srst)
    next_drive.delay_on |=>
    drive.analog_ps == 8'($past(cfg.analog_delay_code) * COB_ANLG_STEP_PS))
    else $error("analog delay step wrong");
endmodule // cob_out_cell
`default_nettype wire

//--- cob_pkg.sv
/*
  cob_pkg: constants and types for the clock output buffer configuration bank.
  Assumes an APB slave with 32-bit data; one register word per output.
*/
`default_nettype none
package cob_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int COB_NUM_OUT = 18;
  localparam int COB_IDX_W = 5;
  localparam logic [4:0] COB_HF_FIRST = 5'h04;
  localparam logic [4:0] COB_HF_LAST = 5'h07;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [11:0] COB_OUT_BASE = 12'h000;
  localparam logic [11:0] COB_OUT_LAST = 12'h044;
  localparam logic [11:0] COB_STAT_ADDR = 12'h080;
  // ----------------------------------------
  // field positions in an output word
  // ----------------------------------------
  localparam int COB_AMP_LSB = 0;
  localparam int COB_STYLE_BIT = 2;
  localparam int COB_INV_BIT = 3;
  localparam int COB_ANLG_LSB = 8;
  localparam int COB_FINE_LSB = 12;
  localparam int COB_PDSYS_BIT = 16;
  localparam int COB_PD_BIT = 17;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic COB_PD_RST = 1'h0;
  localparam logic COB_PDSYS_RST = 1'h1;
  localparam logic COB_INV_RST = 1'h0;
  localparam logic COB_STYLE_RST = 1'h1;
  localparam logic [1:0] COB_AMP_RST = 2'h3;
  localparam logic [2:0] COB_ANLG_RST = 3'h0;
  localparam logic [1:0] COB_FINE_RST = 2'h0;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic COB_STYLE_LVDS = 1'h0;
  localparam logic COB_STYLE_PECL = 1'h1;
  localparam int COB_ANLG_STEP_PS = 30;
  // swing codes in mV
  localparam logic [9:0] COB_MV_OFF = 10'h000;
  localparam logic [9:0] COB_MV_300 = 10'h12C;
  localparam logic [9:0] COB_MV_350 = 10'h15E;
  localparam logic [9:0] COB_MV_400 = 10'h190;
  localparam logic [9:0] COB_MV_500 = 10'h1F4;
  localparam logic [9:0] COB_MV_550 = 10'h226;
  localparam logic [9:0] COB_MV_700 = 10'h2BC;

  typedef struct packed {
    logic output_power_down;
    logic sysref_path_power_down;
    logic [1:0] fine_delay_code;
    logic [2:0] analog_delay_code;
    logic sysref_polarity_invert;
    logic style;
    logic [1:0] amplitude;
  } cob_cfg_t;

  localparam cob_cfg_t COB_CFG_RST = '{COB_PD_RST, COB_PDSYS_RST, COB_FINE_RST,
    COB_ANLG_RST, COB_INV_RST, COB_STYLE_RST, COB_AMP_RST};

  // applied state of one output buffer
  typedef struct packed {
    logic buffer_on;
    logic delay_on;
    logic invert;
    logic style;
    logic [9:0] swing_mv;
    logic [7:0] analog_ps;
    logic [1:0] fine;
  } cob_drive_t;
endpackage
`default_nettype wire

//--- cob_top.sv
/*
  cob_top: APB register bank configuring the clock and SYSREF output buffers.
  Assumes an APB master on ref_clk; one wait state, pslverr on unmapped address.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - output power-down resets 0, 1 powers down
// - powered-down output ignores style and amplitude
// - sysref path power-down resets 1, kills path
// - at 0 delay circuits and buffer stay powered
// - polarity invert resets 0, 1 inverts sysref
// - style resets lvpecl; 0 selects lvds, except outputs 4-7 stay lvpecl
// - amplitude resets 11; lvpecl 300/400/550/700 mV
// - lvds amplitude 350 or 500 mV
// - analog delay adds code times 30 ps
module cob_top
  import cob_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // applied buffer drive, one per output
  output cob_drive_t [COB_NUM_OUT-1:0] out_drive
);
  logic [31:0] rd_words [COB_NUM_OUT];
  logic [COB_NUM_OUT-1:0] wr_sel;
  logic acc;
  logic [4:0] idx;
  logic hit_out;
  logic hit_stat;
  logic [COB_NUM_OUT-1:0] on_mask;

  function automatic logic [4:0] idx_of(input logic [11:0] a);
    return a[6:2];
  endfunction

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign acc = psel & penable;
  assign idx = idx_of(paddr);
  assign hit_out = paddr[1:0] == 2'h0 && paddr >= COB_OUT_BASE && paddr <= COB_OUT_LAST;
  assign hit_stat = paddr == COB_STAT_ADDR;

  // ----------------------------------------
  // output cells
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < COB_NUM_OUT; g++)
    begin : g_out
      // store only at the edge that completes the access
      assign wr_sel[g] = acc & pready & pwrite & hit_out & (idx == 5'(g));
      assign on_mask[g] = out_drive[g].buffer_on;
      cob_out_cell #(
        .HF_OUT(5'(g) >= COB_HF_FIRST && 5'(g) <= COB_HF_LAST)
      ) u_cell (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr_en(wr_sel[g]),
        .wr_data(pwdata),
        .rd_word(rd_words[g]),
        .drive(out_drive[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // apb answer, one wait state
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      pslverr <= ~(hit_out | (hit_stat & ~pwrite));
      if (!pwrite && hit_out)
        prdata <= rd_words[idx];
      else if (!pwrite && hit_stat)
        prdata <= {14'h0000, on_mask};
      else
        prdata <= 32'h00000000;
    end
  end

  unmapped_err_a: assert property (@(posedge ref_clk) disable iff (srst)
    acc && !pready && !hit_out && !hit_stat |=> pready && pslverr)
    else $error("unmapped access not flagged");
endmodule // cob_top
`default_nettype wire

//--- test_clock_output_buffer_config.sv
/*
  test_clock_output_buffer_config: self-checking bench for cob_top.
  Assumes cob_pkg is compiled first; the bench drives APB itself, no partner model.
*/
`timescale 1ns/100ps
`default_nettype none
module test_clock_output_buffer_config;
  import cob_pkg::*;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  cob_drive_t [COB_NUM_OUT-1:0] out_drive;
  logic [33:0] exp_q[$];
  logic [31:0] sh[COB_NUM_OUT];
  int num_errors, check_count, cycles;

  cob_top u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_drive(out_drive));

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // answer monitor: oldest note against each completed access
  always @(posedge ref_clk)
    if (pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        if (exp_q[0][33])
          check(prdata, exp_q[0][32:1]);
        check({31'h0, pslverr}, {31'h0, exp_q[0][0]});
        void'(exp_q.pop_front());
      end
    end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // expectations and bus tasks
  // ----------------------------------------
  function automatic cob_drive_t exp_drv(input int n, input logic [31:0] w);
    cob_drive_t r;
    logic sty;
    r = '0;
    sty = (n >= 4 && n <= 7) ? 1'b1 : w[2];
    r.buffer_on = ~w[17] & ~w[16];
    r.delay_on = ~w[16];
    if (r.buffer_on)
    begin
      r.invert = w[3];
      r.style = sty;
      r.swing_mv = sty ? (w[1] ? (w[0] ? COB_MV_700 : COB_MV_550)
        : (w[0] ? COB_MV_400 : COB_MV_300)) : (w[1] ? COB_MV_500 : COB_MV_350);
    end
    if (r.delay_on)
    begin
      r.analog_ps = 8'(w[10:8] * 30);
      r.fine = w[13:12];
    end
    return r;
  endfunction

  // one access; rd_cmp selects a read data compare
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic rd_cmp, input logic [31:0] exp_d, input logic exp_e);
    exp_q.push_back({rd_cmp, exp_d, exp_e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input int n, input logic [31:0] w);
    logic [31:0] v;
    v = (n >= 4 && n <= 7) ? (w | 32'h00000004) : w;
    apb(1'b1, 12'(4 * n), v, 1'b0, 32'h0, 1'b0);
    sh[n] = v;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic check_all();
    cob_drive_t e;
    logic [31:0] st;
    st = '0;
    for (int n = 0; n < COB_NUM_OUT; n++)
    begin
      e = exp_drv(n, sh[n]);
      st[n] = e.buffer_on;
      if (sh[n][17] && !sh[n][16])
        check(32'(out_drive[n]), 32'(e));
      else
        check(32'(out_drive[n]), 32'(e));
      apb(1'b0, 12'(4 * n), 0, 1'b1, (sh[n] & 32'h0003370F) | ((n >= 4 && n <= 7) ? 4 : 0),
        1'b0);
    end
    apb(1'b0, COB_STAT_ADDR, 0, 1'b1, st, 1'b0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 0;
    srst = 1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    foreach (sh[n]) sh[n] = 32'h00010007;
    repeat (12) @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    void'($urandom(1980));
    check_all();
    for (int k = 0; k < 16; k++)
    begin
      wr(k[3] ? 4 : 0, 32'(k[2:0]) | (32'(k[2:0]) << 8) | 32'h00001008);
      check_all();
    end
    for (int r = 0; r < 30; r++)
    begin
      wr($urandom % COB_NUM_OUT, $urandom);
      check_all();
    end
    apb(1'b1, COB_STAT_ADDR, 32'hFFFFFFFF, 1'b0, 0, 1'b1);
    apb(1'b0, 12'h048, 0, 1'b0, 0, 1'b1);
    apb(1'b1, 12'h002, 32'h00030000, 1'b0, 0, 1'b1);
    repeat (3) @(posedge ref_clk);
    check_all();
    print_verdict();
  end
endmodule // test_clock_output_buffer_config
`default_nettype wire
